// file: hdl/bsmw_cfg.svh
/*
 * Offsets, field positions, reset values and fixed codes of the secondary
 * status and memory window registers.
 * Assumes it is included by bare name wherever these constants are needed.
 */
`ifndef BSMW_CFG_SVH
`define BSMW_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define BSMW_OFS_COMMAND      8'h04
`define BSMW_OFS_SEC_STATUS   8'h1c
`define BSMW_OFS_MEM_WINDOW   8'h20
`define BSMW_OFS_PF_WINDOW    8'h24
`define BSMW_OFS_PF_BASE_UP   8'h28
`define BSMW_OFS_PF_LIMIT_UP  8'h2c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BSMW_POS_PERR_RESP    6
`define BSMW_POS_CAP66        21
`define BSMW_POS_FAST_B2B     23
`define BSMW_POS_PERR_DET     24
`define BSMW_POS_DSEL_LO      25
`define BSMW_POS_SIG_TA       27
`define BSMW_POS_RCV_TA       28
`define BSMW_POS_RCV_MA       29
`define BSMW_POS_RCV_SERR     30
`define BSMW_POS_DET_PE       31
`define BSMW_POS_BASE_LO      4
`define BSMW_POS_LIMIT_LO     20
`define BSMW_POS_LIMIT_TYPE   16

// ----------------------------------------------------------------
// Fixed codes and reset values
// ----------------------------------------------------------------
`define BSMW_CAP66_VAL        1'h1
`define BSMW_FAST_B2B_VAL     1'h0
`define BSMW_DSEL_MEDIUM      2'h1
`define BSMW_ADDR_TYPE_64     4'h1
`define BSMW_ADDR_TYPE_ZERO   4'h0
`define BSMW_WIN_RST          12'h000
`define BSMW_UP_RST           32'h0000_0000
`define BSMW_LOW_BOTTOM       20'h0_0000
`define BSMW_LOW_TOP          20'hf_ffff

`endif

// file: hdl/bsmw_pkg.sv
/*
 * Types shared by the window register block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package bsmw_pkg;
	typedef logic [7:0]  bsmw_addr_t;
	typedef logic [31:0] bsmw_word_t;
	typedef logic [11:0] bsmw_win_t;
endpackage : bsmw_pkg

// file: hdl/bsmw_sync.sv
/*
 * Two-stage synchroniser for pin levels.
 * Assumes inputs are asynchronous to clk_i; only the second stage is read.
 */
`timescale 1ns/10ps
`default_nettype none
module bsmw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= RST_VAL;
			q_o      <= RST_VAL;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end
endmodule : bsmw_sync
`default_nettype wire

// file: hdl/bsmw_win.sv
/*
 * Inclusive address window compare: bottom <= addr <= top.
 * Assumes the bounds are already widened with their fixed low bits.
 */
`timescale 1ns/10ps
`default_nettype none
module bsmw_win #(
	parameter int W = 64
) (
	input  wire logic [W-1:0] addr_i,
	input  wire logic [W-1:0] bottom_i,
	input  wire logic [W-1:0] top_i,
	output logic              hit_o
);
	// Bounds carry 20 fixed low bits, so narrower addresses make no sense
	if (W < 21) begin : g_bad_width
		$error("bsmw_win: W must be at least 21");
	end

	// An inverted window (bottom above top) matches nothing
	assign hit_o = (addr_i >= bottom_i) && (addr_i <= top_i);
endmodule : bsmw_win
`default_nettype wire

// file: hdl/bsmw_top.sv
/*
 * Secondary status register and memory / prefetchable forwarding windows
 * of a two-port bridge, reached over a simple strobe register port.
 * Assumes event inputs come from bridge logic on ref_clk_i, while the two
 * secondary error pins are asynchronous and active low.
 */
// Chosen here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bsmw_cfg.svh"

// Operation
// - Status bit 21 is read-only and reads one: 66 MHz capable.
// - Status bit 23 is read-only and reads zero: no fast back-to-back.
// - Bit 24 sets on secondary parity pin while command bit 6 set; write one clears.
// - Bits 26:25 read-only, return 01 for medium device-select timing.
// - Bit 27 sets when bridge as secondary target signals target abort; W1C.
// - Bit 28 sets when bridge-mastered secondary transaction gets target abort; W1C.
// - Bit 29 sets when bridge-mastered secondary transaction gets master abort; W1C.
// - Bit 30 sets while secondary system error pin asserted; W1C.
// - Bit 31 sets on any secondary address or data parity error; W1C.
// - Low four bits of memory base and memory limit read zero.
// - Memory base bits 15:4 writable, reset zero, give bottom address 31:20.
// - Memory limit bits 31:20 writable, give top address 31:20, low bits FFFFFh.
// - Memory window decides forwarding of memory transactions between interfaces.
// - Prefetchable base and limit type nibbles read 0001, meaning 64-bit.
// - Prefetchable base bits 15:4 writable, give bottom address 31:20.
// - Prefetchable limit bits 31:20 writable, give top address 31:20, low FFFFFh.
// - Prefetchable window decides forwarding of memory reads and writes.
// - Upper prefetchable halves at 28h and 2Ch extend the 64-bit window; reset zero.
module bsmw_top (
	input  wire logic                ref_clk_i,
	input  wire logic                sys_rst_i,
	input  wire bsmw_pkg::bsmw_addr_t reg_addr_i,
	input  wire bsmw_pkg::bsmw_word_t reg_wdata_i,
	input  wire logic                reg_wr_i,
	input  wire logic                reg_rd_i,
	output var  bsmw_pkg::bsmw_word_t reg_rdata_o,
	input  wire logic                secondary_parity_error_n_i,
	input  wire logic                secondary_system_error_n_i,
	input  wire logic                sec_target_abort_sent_i,
	input  wire logic                sec_target_abort_rcvd_i,
	input  wire logic                sec_master_abort_rcvd_i,
	input  wire logic                sec_parity_detected_i,
	input  wire logic                txn_valid_i,
	input  wire logic                txn_is_mem_i,
	input  wire logic                txn_from_sec_i,
	input  wire logic [63:0]         txn_addr_i,
	output var  logic                fwd_valid_o,
	output var  logic                fwd_o,
	output var  logic                mem_hit_o,
	output var  logic                pf_hit_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic                perr_resp_reg;
	logic                perr_det_reg;
	logic                sig_ta_reg;
	logic                rcv_ta_reg;
	logic                rcv_ma_reg;
	logic                rcv_serr_reg;
	logic                det_pe_reg;
	bsmw_pkg::bsmw_win_t mem_base_reg;
	bsmw_pkg::bsmw_win_t mem_limit_reg;
	bsmw_pkg::bsmw_win_t pf_base_reg;
	bsmw_pkg::bsmw_win_t pf_limit_reg;
	bsmw_pkg::bsmw_word_t pf_base_up_reg;
	bsmw_pkg::bsmw_word_t pf_limit_up_reg;
	logic [1:0]          pin_sync;
	logic                perr_pin;
	logic                serr_pin;
	logic                mem_hit;
	logic                pf_hit;
	logic                wr_status;
	logic                wr_mem;
	logic                wr_pf;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Write-one-to-clear with the hardware set winning the tie
	function automatic logic w1c_next(input logic cur, input logic set,
		input logic clr);
		w1c_next = set | (cur & ~clr);
	endfunction : w1c_next

	function automatic logic wr_hit(input bsmw_pkg::bsmw_addr_t ofs);
		wr_hit = reg_wr_i && (reg_addr_i == ofs);
	endfunction : wr_hit

	// A process, not assign: it must also wake on the strobe and address read inside wr_hit
	always_comb begin
		wr_status = wr_hit(`BSMW_OFS_SEC_STATUS);
		wr_mem    = wr_hit(`BSMW_OFS_MEM_WINDOW);
		wr_pf     = wr_hit(`BSMW_OFS_PF_WINDOW);
	end

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	bsmw_sync #(
		.W       (2),
		.RST_VAL (2'h3)
	) u_pin_sync (
		.clk_i (ref_clk_i),
		.rst_i (sys_rst_i),
		.d_i   ({secondary_system_error_n_i, secondary_parity_error_n_i}),
		.q_o   (pin_sync)
	);

	assign perr_pin = ~pin_sync[0];
	assign serr_pin = ~pin_sync[1];

	// ----------------------------------------------------------------
	// Command shadow: parity error response enable
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			perr_resp_reg <= 1'h0;
		end else if (wr_hit(`BSMW_OFS_COMMAND)) begin
			perr_resp_reg <= reg_wdata_i[`BSMW_POS_PERR_RESP];
		end
	end

	// ----------------------------------------------------------------
	// Secondary status flags
	// ----------------------------------------------------------------
	// Pins are levels, so a held error keeps re-setting the flag and a
	// clear only sticks once the pin has gone away.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			perr_det_reg <= 1'h0;
			sig_ta_reg   <= 1'h0;
			rcv_ta_reg   <= 1'h0;
			rcv_ma_reg   <= 1'h0;
			rcv_serr_reg <= 1'h0;
			det_pe_reg   <= 1'h0;
		end else begin
			perr_det_reg <= w1c_next(perr_det_reg, perr_pin & perr_resp_reg,
				wr_status & reg_wdata_i[`BSMW_POS_PERR_DET]);
			sig_ta_reg   <= w1c_next(sig_ta_reg, sec_target_abort_sent_i,
				wr_status & reg_wdata_i[`BSMW_POS_SIG_TA]);
			rcv_ta_reg   <= w1c_next(rcv_ta_reg, sec_target_abort_rcvd_i,
				wr_status & reg_wdata_i[`BSMW_POS_RCV_TA]);
			rcv_ma_reg   <= w1c_next(rcv_ma_reg, sec_master_abort_rcvd_i,
				wr_status & reg_wdata_i[`BSMW_POS_RCV_MA]);
			rcv_serr_reg <= w1c_next(rcv_serr_reg, serr_pin,
				wr_status & reg_wdata_i[`BSMW_POS_RCV_SERR]);
			det_pe_reg   <= w1c_next(det_pe_reg, sec_parity_detected_i,
				wr_status & reg_wdata_i[`BSMW_POS_DET_PE]);
		end
	end

	// ----------------------------------------------------------------
	// Window registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			mem_base_reg  <= `BSMW_WIN_RST;
			mem_limit_reg <= `BSMW_WIN_RST;
		end else if (wr_mem) begin
			mem_base_reg  <= reg_wdata_i[15:`BSMW_POS_BASE_LO];
			mem_limit_reg <= reg_wdata_i[31:`BSMW_POS_LIMIT_LO];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pf_base_reg  <= `BSMW_WIN_RST;
			pf_limit_reg <= `BSMW_WIN_RST;
		end else if (wr_pf) begin
			pf_base_reg  <= reg_wdata_i[15:`BSMW_POS_BASE_LO];
			pf_limit_reg <= reg_wdata_i[31:`BSMW_POS_LIMIT_LO];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			pf_base_up_reg  <= `BSMW_UP_RST;
			pf_limit_up_reg <= `BSMW_UP_RST;
		end else begin
			if (wr_hit(`BSMW_OFS_PF_BASE_UP)) begin
				pf_base_up_reg <= reg_wdata_i;
			end
			if (wr_hit(`BSMW_OFS_PF_LIMIT_UP)) begin
				pf_limit_up_reg <= reg_wdata_i;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Read-only fields are rebuilt here from constants, so no write can
	// ever reach them.
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`BSMW_OFS_COMMAND: begin
					reg_rdata_o <= 32'(perr_resp_reg) << `BSMW_POS_PERR_RESP;
				end
				`BSMW_OFS_SEC_STATUS: begin
					reg_rdata_o <= {det_pe_reg, rcv_serr_reg, rcv_ma_reg,
						rcv_ta_reg, sig_ta_reg, `BSMW_DSEL_MEDIUM,
						perr_det_reg, `BSMW_FAST_B2B_VAL, 1'h0,
						`BSMW_CAP66_VAL, 5'h00, 16'h0000};
				end
				`BSMW_OFS_MEM_WINDOW: begin
					reg_rdata_o <= {mem_limit_reg, `BSMW_ADDR_TYPE_ZERO,
						mem_base_reg, `BSMW_ADDR_TYPE_ZERO};
				end
				`BSMW_OFS_PF_WINDOW: begin
					reg_rdata_o <= {pf_limit_reg, `BSMW_ADDR_TYPE_64,
						pf_base_reg, `BSMW_ADDR_TYPE_64};
				end
				`BSMW_OFS_PF_BASE_UP: begin
					reg_rdata_o <= pf_base_up_reg;
				end
				`BSMW_OFS_PF_LIMIT_UP: begin
					reg_rdata_o <= pf_limit_up_reg;
				end
				default: begin
					reg_rdata_o <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Forwarding decode
	// ----------------------------------------------------------------
	// The plain memory window is 32-bit only: any upper address bit set
	// misses it.
	bsmw_win #(
		.W (64)
	) u_mem_win (
		.addr_i   (txn_addr_i),
		.bottom_i ({32'h0000_0000, mem_base_reg, `BSMW_LOW_BOTTOM}),
		.top_i    ({32'h0000_0000, mem_limit_reg, `BSMW_LOW_TOP}),
		.hit_o    (mem_hit)
	);

	bsmw_win #(
		.W (64)
	) u_pf_win (
		.addr_i   (txn_addr_i),
		.bottom_i ({pf_base_up_reg, pf_base_reg, `BSMW_LOW_BOTTOM}),
		.top_i    ({pf_limit_up_reg, pf_limit_reg, `BSMW_LOW_TOP}),
		.hit_o    (pf_hit)
	);

	// Downstream traffic crosses when inside a window, upstream when outside
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			fwd_valid_o <= 1'h0;
			fwd_o       <= 1'h0;
			mem_hit_o   <= 1'h0;
			pf_hit_o    <= 1'h0;
		end else begin
			fwd_valid_o <= txn_valid_i;
			mem_hit_o   <= txn_valid_i & mem_hit;
			pf_hit_o    <= txn_valid_i & pf_hit;
			fwd_o       <= txn_valid_i & txn_is_mem_i &
				(txn_from_sec_i ^ (mem_hit | pf_hit));
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	logic rd_status;
	assign rd_status = reg_rd_i && (reg_addr_i == `BSMW_OFS_SEC_STATUS);

	a_cap66_reads_one: assert property (rd_status |=> reg_rdata_o[21] == 1'h1)
		else $error("66 MHz capable bit not one");
	a_fast_b2b_zero: assert property (rd_status |=> reg_rdata_o[23] == 1'h0)
		else $error("fast back-to-back bit not zero");
	a_perr_pin_sets: assert property (
		(!secondary_parity_error_n_i && perr_resp_reg) [*3] |=> perr_det_reg)
		else $error("parity pin did not set bit 24");
	a_perr_gated_off: assert property (
		(!perr_resp_reg && !perr_det_reg) [*2] |=> !perr_det_reg)
		else $error("bit 24 set with response disabled");
	a_devsel_medium: assert property (rd_status |=> reg_rdata_o[26:25] == 2'h1)
		else $error("device-select timing not medium");
	a_sig_ta_sets: assert property (sec_target_abort_sent_i |=> sig_ta_reg)
		else $error("signalled target abort not recorded");
	a_rcv_ta_sets: assert property (sec_target_abort_rcvd_i |=> rcv_ta_reg)
		else $error("received target abort not recorded");
	a_rcv_ma_sets: assert property (sec_master_abort_rcvd_i |=> rcv_ma_reg)
		else $error("received master abort not recorded");
	a_serr_pin_sets: assert property (
		!secondary_system_error_n_i [*3] |=> rcv_serr_reg)
		else $error("system error pin did not set bit 30");
	a_det_pe_sets: assert property (sec_parity_detected_i |=> det_pe_reg)
		else $error("detected parity error not recorded");
	a_mem_low_zero: assert property (
		reg_rd_i && reg_addr_i == `BSMW_OFS_MEM_WINDOW
		|=> reg_rdata_o[3:0] == 4'h0 && reg_rdata_o[19:16] == 4'h0)
		else $error("memory window low nibbles not zero");
	a_mem_base_write: assert property (
		wr_mem |=> mem_base_reg == $past(reg_wdata_i[15:4])
		&& mem_limit_reg == $past(reg_wdata_i[31:20]))
		else $error("memory window write not taken");
	a_mem_decode: assert property (
		txn_valid_i && txn_addr_i[63:32] == 32'h0 && txn_addr_i[31:20] >= mem_base_reg
		&& txn_addr_i[31:20] <= mem_limit_reg |=> mem_hit_o)
		else $error("address inside memory window missed");
	a_pf_type_nibble: assert property (
		reg_rd_i && reg_addr_i == `BSMW_OFS_PF_WINDOW
		|=> reg_rdata_o[3:0] == 4'h1 && reg_rdata_o[19:16] == 4'h1)
		else $error("prefetchable type nibble not 64-bit");
	a_pf_decode: assert property (
		txn_valid_i && txn_addr_i[63:20] == {pf_base_up_reg, pf_base_reg}
		&& {pf_base_up_reg, pf_base_reg} <= {pf_limit_up_reg, pf_limit_reg}
		|=> pf_hit_o)
		else $error("prefetchable window bottom missed");
	a_fwd_down: assert property (
		txn_valid_i && txn_is_mem_i && !txn_from_sec_i && !mem_hit && !pf_hit
		|=> fwd_valid_o && !fwd_o)
		else $error("miss from primary forwarded");
	a_w1c_zero_keeps: assert property (
		wr_status && !reg_wdata_i[27] && sig_ta_reg |=> sig_ta_reg)
		else $error("writing zero cleared bit 27");
	a_w1c_set_wins: assert property (
		wr_status && reg_wdata_i[29] && sec_master_abort_rcvd_i |=> rcv_ma_reg)
		else $error("clear beat a coinciding set");
	a_w1c_clears: assert property (
		wr_status && reg_wdata_i[28] && !sec_target_abort_rcvd_i |=> !rcv_ta_reg)
		else $error("writing one did not clear bit 28");
	a_reserved_zero: assert property (
		rd_status |=> reg_rdata_o[22:0] == 23'h20_0000)
		else $error("reserved status bits not zero");

	c_status_clear: cover property (sig_ta_reg ##1 wr_status ##1 !sig_ta_reg);
	c_mem_forward: cover property (fwd_valid_o && fwd_o && mem_hit_o);
	c_pf_forward: cover property (fwd_valid_o && fwd_o && pf_hit_o);
	c_upstream: cover property (txn_valid_i && txn_from_sec_i ##1 fwd_o);
endmodule : bsmw_top
`default_nettype wire

// file: dv/bsmw_sec_agent.sv
/*
 * Model of the secondary side: the two error pins and the event pulses
 * that the bridge's bus logic raises.
 * Assumes one clock shared with the register block; pins have pull-ups;
 * tasks are entered on a rising edge and return on one.
 */
`timescale 1ns/10ps
`default_nettype none
module bsmw_sec_agent (
	input  wire logic clk_i,
	output logic      perr_n_o,
	output logic      serr_n_o,
	output logic      ta_sent_o,
	output logic      ta_rcvd_o,
	output logic      ma_rcvd_o,
	output logic      pe_det_o
);
	// ----------------------------------------------------------------
	// Drive state
	// ----------------------------------------------------------------
	logic [3:0] ev    = 4'h0;
	logic [1:0] pin_n = 2'h3;

	assign {pe_det_o, ma_rcvd_o, ta_rcvd_o, ta_sent_o} = ev;
	assign perr_n_o = pin_n[0];
	assign serr_n_o = pin_n[1];

	// ----------------------------------------------------------------
	// Actions
	// ----------------------------------------------------------------
	// One-cycle event: 0 target abort sent, 1 target abort seen, 2 master abort, 3 parity
	task automatic pulse(input int k);
		ev[k] <= 1'h1;
		@(posedge clk_i);
		ev[k] <= 1'h0;
	endtask : pulse

	// Released pins float high; the settle time lets the synchroniser drain
	task automatic pin(input int k, input int n);
		pin_n[k] <= 1'h0;
		repeat (n) @(posedge clk_i);
		pin_n[k] <= 1'h1;
		repeat (3) @(posedge clk_i);
	endtask : pin
endmodule : bsmw_sec_agent
`default_nettype wire

// file: dv/bsmw_top_test.sv
/*
 * Self-checking bench for the secondary status and window block.
 * Assumes the design files and the secondary agent model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
module bsmw_top_test;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam bsmw_pkg::bsmw_word_t ST0 = 32'h0220_0000;
	logic                 clk   = 1'h0;
	logic                 rst   = 1'h1;
	bsmw_pkg::bsmw_addr_t addr  = 8'h00;
	bsmw_pkg::bsmw_word_t wdata = 32'h0;
	logic                 wr_s  = 1'h0;
	logic                 rd_s  = 1'h0;
	bsmw_pkg::bsmw_word_t rdata;
	logic                 perr_n, serr_n, ta_s, ta_r, ma_r, pe_d;
	logic                 tv    = 1'h0;
	logic                 tm    = 1'h0;
	logic                 ts    = 1'h0;
	logic [63:0]          ta    = 64'h0;
	logic                 fv, fwd, mh, ph;
	int                   n_fail = 0;
	int                   n_compared = 0;
	int                   cyc = 0;

	bsmw_top i_bsmw_top (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
		.reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .secondary_parity_error_n_i(perr_n),
		.secondary_system_error_n_i(serr_n), .sec_target_abort_sent_i(ta_s), .sec_target_abort_rcvd_i(ta_r),
		.sec_master_abort_rcvd_i(ma_r), .sec_parity_detected_i(pe_d), .txn_valid_i(tv), .txn_is_mem_i(tm),
		.txn_from_sec_i(ts), .txn_addr_i(ta), .fwd_valid_o(fv), .fwd_o(fwd), .mem_hit_o(mh), .pf_hit_o(ph));

	bsmw_sec_agent i_bsmw_sec_agent (.clk_i(clk), .perr_n_o(perr_n), .serr_n_o(serr_n),
		.ta_sent_o(ta_s), .ta_rcvd_o(ta_r), .ma_rcvd_o(ma_r), .pe_det_o(pe_d));

	initial begin
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// An idle cycle follows each access so a strobe is never reassigned in one step
	task automatic wr(input bsmw_pkg::bsmw_addr_t a, input bsmw_pkg::bsmw_word_t d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input bsmw_pkg::bsmw_addr_t a, input bsmw_pkg::bsmw_word_t e);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : rd

	task automatic txn(input logic m, input logic s, input logic [63:0] a, input logic me, input logic pe);
		logic f;
		f = m & (s ? !(me | pe) : (me | pe));
		tv <= 1'h1;
		tm <= m;
		ts <= s;
		ta <= a;
		@(posedge clk);
		tv <= 1'h0;
		#1 chk({30'h0, fv, fwd}, {30'h0, 1'h1, f});
		chk({30'h0, mh, ph}, {30'h0, me, pe});
		@(posedge clk);
		#1 chk({28'h0, fv, fwd, mh, ph}, 32'h0);
		@(posedge clk);
	endtask : txn

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		rd(8'h1c, ST0);
		rd(8'h20, 32'h0);
		rd(8'h24, 32'h0001_0001);
		rd(8'h28, 32'h0);
		rd(8'h2c, 32'h0);
		rd(8'h04, 32'h0);
	endtask : t_reset

	task automatic t_access();
		wr(8'h1c, 32'hffff_ffff);
		rd(8'h1c, ST0);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'hfff0_fff0);
		wr(8'h24, 32'hffff_ffff);
		rd(8'h24, 32'hfff1_fff1);
		wr(8'h28, 32'ha5a5_5a5a);
		rd(8'h28, 32'ha5a5_5a5a);
		wr(8'h2c, 32'h5a5a_a5a5);
		rd(8'h2c, 32'h5a5a_a5a5);
		wr(8'h30, 32'hffff_ffff);
		rd(8'h30, 32'h0);
	endtask : t_access

	task automatic t_events();
		int bits[4] = '{27, 28, 29, 31};
		for (int k = 0; k < 4; k++) begin
			i_bsmw_sec_agent.pulse(k);
			rd(8'h1c, ST0 | (32'h1 << bits[k]));
			wr(8'h1c, 32'h0);
			rd(8'h1c, ST0 | (32'h1 << bits[k]));
			wr(8'h1c, 32'h1 << bits[k]);
			rd(8'h1c, ST0);
		end
	endtask : t_events

	// Parity pin counts only once response is enabled; system error pin always counts
	task automatic t_pins();
		i_bsmw_sec_agent.pin(0, 4);
		rd(8'h1c, ST0);
		wr(8'h04, 32'h0000_0040);
		rd(8'h04, 32'h0000_0040);
		i_bsmw_sec_agent.pin(0, 4);
		rd(8'h1c, ST0 | 32'h0100_0000);
		wr(8'h1c, 32'h0100_0000);
		rd(8'h1c, ST0);
		i_bsmw_sec_agent.pin(1, 4);
		rd(8'h1c, ST0 | 32'h4000_0000);
		wr(8'h1c, 32'h4000_0000);
		rd(8'h1c, ST0);
	endtask : t_pins

	task automatic t_set_wins();
		fork
			wr(8'h1c, 32'h2000_0000);
			i_bsmw_sec_agent.pulse(2);
		join
		rd(8'h1c, ST0 | 32'h2000_0000);
		wr(8'h1c, 32'h2000_0000);
		rd(8'h1c, ST0);
	endtask : t_set_wins

	// Prefetch window left inverted from t_access, so only the memory window can hit first
	task automatic t_decode();
		wr(8'h20, 32'h0120_0010);
		txn(1'h1, 1'h0, 64'h0010_0000, 1'h1, 1'h0);
		txn(1'h1, 1'h0, 64'h012f_ffff, 1'h1, 1'h0);
		txn(1'h1, 1'h0, 64'h0130_0000, 1'h0, 1'h0);
		txn(1'h1, 1'h0, 64'h000f_ffff, 1'h0, 1'h0);
		txn(1'h1, 1'h1, 64'h0130_0000, 1'h0, 1'h0);
		txn(1'h1, 1'h1, 64'h0010_0000, 1'h1, 1'h0);
		txn(1'h1, 1'h0, 64'h1_0010_0000, 1'h0, 1'h0);
		txn(1'h0, 1'h0, 64'h0010_0000, 1'h1, 1'h0);
		txn(1'h0, 1'h1, 64'h0130_0000, 1'h0, 1'h0);
		wr(8'h28, 32'h1);
		wr(8'h2c, 32'h1);
		wr(8'h24, 32'h1000_1000);
		txn(1'h1, 1'h0, 64'h1_1000_0000, 1'h0, 1'h1);
		txn(1'h1, 1'h0, 64'h1_100f_ffff, 1'h0, 1'h1);
		txn(1'h1, 1'h0, 64'h1_1010_0000, 1'h0, 1'h0);
		txn(1'h1, 1'h0, 64'h0_1000_0000, 1'h0, 1'h0);
		txn(1'h1, 1'h1, 64'h1_1000_0000, 1'h0, 1'h1);
	endtask : t_decode

	// ----------------------------------------------------------------
	// Sequence and verdict
	// ----------------------------------------------------------------
	task automatic conclude();
		if (n_fail == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : conclude

	// Whole run is well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_access();
		t_events();
		t_pins();
		t_set_wins();
		t_decode();
		conclude();
	end
endmodule : bsmw_top_test
`default_nettype wire
